// ---- hw/ase_cfg.svh ----
// Offsets, field positions, reset values and widths of the audio serial event control block
`ifndef ASE_CFG_SVH
`define ASE_CFG_SVH
`define ASE_OFF_START       12'h000
`define ASE_OFF_STOP        12'h004
`define ASE_OFF_SUB_START   12'h080
`define ASE_OFF_SUB_STOP    12'h084
`define ASE_OFF_EV_RXPU     12'h104
`define ASE_OFF_EV_STOPPED  12'h108
`define ASE_OFF_EV_TXPU     12'h114
`define ASE_OFF_EV_FRAME    12'h11C
`define ASE_OFF_PUB_RXPU    12'h184
`define ASE_OFF_PUB_STOPPED 12'h188
`define ASE_OFF_PUB_TXPU    12'h194
`define ASE_OFF_PUB_FRAME   12'h19C
`define ASE_OFF_IRQ_EN      12'h300
`define ASE_OFF_IRQ_SET     12'h304
`define ASE_OFF_IRQ_CLR     12'h308
`define ASE_OFF_RXEN        12'h508
`define ASE_OFF_TXEN        12'h50C
`define ASE_OFF_CLKGEN      12'h510
`define ASE_OFF_BUFCNT      12'h550
// Field positions
`define ASE_EN_BIT          31
`define ASE_IDX_W           8
`define ASE_INT_RXPU_BIT    1
`define ASE_INT_STOP_BIT    2
`define ASE_INT_TXPU_BIT    5
`define ASE_INT_FRAME_BIT   7
// Reset values
`define ASE_RST_PUB         32'h0000_0000
`define ASE_RST_IRQ_EN      4'h0
`define ASE_RST_CLKGEN      1'b1
`define ASE_RST_BUFCNT      14'h0000
// Widths
`define ASE_CNT_W           14
`define ASE_NUM_EV          4
`endif

// ---- hw/ase_event_ctrl.sv ----
// Task, event, publish and interrupt control of the audio serial unit, APB slave
//
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
`include "ase_cfg.svh"

// Contract
// - start task begins transfer and clock generator
// - stop task halts transfer, raises stopped
// - stopped flag set once transfer stopped
// - rx pointer event each buffer of words
// - tx pointer event each buffer of words
// - frame begin flag on word-select active edge
// - subscription registers for start and stop
// - publish register holds channel index 0-255
// - publish enable bit gates channel output
// - publish registers reset to zero
// - interrupt enable register, one bit each
// - set register enables, reads enable state
// - interrupt enables cleared by reset
// - clear register disables, reads enable state
// - buffer size register paces pointer events
module ase_event_ctrl #(
    parameter int NUM_CHAN = 256
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 serial_bit_clock,
    input  wire logic                 frame_word_select,
    input  wire logic [NUM_CHAN-1:0]  chan_trigger,
    output logic      [NUM_CHAN-1:0]  chan_publish,
    output logic                      transfer_running,
    output logic                      master_clock_generator_run,
    output logic                      rx_pointer_load,
    output logic                      tx_pointer_load,
    output logic                      irq
);
    import ase_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Event vector to interrupt register layout
    function automatic logic [31:0] ev_to_reg(input logic [`ASE_NUM_EV-1:0] ev);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[`ASE_INT_RXPU_BIT]  = ev[0];
        r[`ASE_INT_STOP_BIT]  = ev[1];
        r[`ASE_INT_TXPU_BIT]  = ev[2];
        r[`ASE_INT_FRAME_BIT] = ev[3];
        return r;
    endfunction : ev_to_reg

    // Interrupt register layout to event vector
    function automatic logic [`ASE_NUM_EV-1:0] reg_to_ev(input logic [31:0] r);
        return {r[`ASE_INT_FRAME_BIT], r[`ASE_INT_TXPU_BIT],
                r[`ASE_INT_STOP_BIT], r[`ASE_INT_RXPU_BIT]};
    endfunction : reg_to_ev

    // Write of a one to a task register
    function automatic logic task_write(input logic        acc,
                                        input logic [11:0] a,
                                        input logic [11:0] off,
                                        input logic [31:0] d);
        return acc && (a == off) && d[0];
    endfunction : task_write

    // Subscribed channel fires a task only while its enable is set
    function automatic logic sub_fire(input logic                  en,
                                      input logic [`ASE_IDX_W-1:0] idx,
                                      input logic [NUM_CHAN-1:0]   chans);
        return en && chans[idx];
    endfunction : sub_fire

    // Map a known register offset, else flag an error
    function automatic logic addr_valid(input logic [11:0] a);
        case (a)
            `ASE_OFF_START,
            `ASE_OFF_STOP,
            `ASE_OFF_SUB_START,
            `ASE_OFF_SUB_STOP,
            `ASE_OFF_EV_RXPU,
            `ASE_OFF_EV_STOPPED,
            `ASE_OFF_EV_TXPU,
            `ASE_OFF_EV_FRAME,
            `ASE_OFF_PUB_RXPU,
            `ASE_OFF_PUB_STOPPED,
            `ASE_OFF_PUB_TXPU,
            `ASE_OFF_PUB_FRAME,
            `ASE_OFF_IRQ_EN,
            `ASE_OFF_IRQ_SET,
            `ASE_OFF_IRQ_CLR,
            `ASE_OFF_RXEN,
            `ASE_OFF_TXEN,
            `ASE_OFF_CLKGEN,
            `ASE_OFF_BUFCNT:
                return 1'b1;
            default:
                return 1'b0;
        endcase
    endfunction : addr_valid

    // Event offsets and publish offsets indexed by event number
    localparam logic [`ASE_NUM_EV-1:0][11:0] EV_OFF = {
        `ASE_OFF_EV_FRAME,
        `ASE_OFF_EV_TXPU,
        `ASE_OFF_EV_STOPPED,
        `ASE_OFF_EV_RXPU
    };
    localparam logic [`ASE_NUM_EV-1:0][11:0] PUB_OFF = {
        `ASE_OFF_PUB_FRAME,
        `ASE_OFF_PUB_TXPU,
        `ASE_OFF_PUB_STOPPED,
        `ASE_OFF_PUB_RXPU
    };

    ////////////////////////////////////////////////////////////////////////////
    // State

    ase_state_t st_r;
    ase_state_t st_nxt;

    logic                   wr_acc;
    logic                   rd_setup;
    logic                   trig_start;
    logic                   trig_stop;
    logic                   sck_rise;
    logic                   word_edge;
    logic [`ASE_NUM_EV-1:0] ev;
    logic [31:0]            rd_val;

    // Bus phases; no wait states, so access is one cycle
    assign wr_acc   = psel && penable && pwrite && addr_valid(paddr);
    assign rd_setup = psel && !penable && !pwrite;

    // Tasks from a write of one or a subscribed channel
    assign trig_start = task_write(wr_acc, paddr, `ASE_OFF_START, pwdata)
                      || sub_fire(st_r.sub_start_en, st_r.sub_start_idx, chan_trigger);
    assign trig_stop  = task_write(wr_acc, paddr, `ASE_OFF_STOP, pwdata)
                      || sub_fire(st_r.sub_stop_en, st_r.sub_stop_idx, chan_trigger);

    // Link edges seen through the second sync stage only
    assign sck_rise  = st_r.sck_sync[1] && !st_r.sck_prev;
    assign word_edge = sck_rise && (st_r.fws_sync[1] != st_r.fws_smp);

    ////////////////////////////////////////////////////////////////////////////
    // Read mux

    always_comb begin
        rd_val = 32'h0000_0000;
        for (int i = 0; i < `ASE_NUM_EV; i++) begin
            if (paddr == EV_OFF[i])
                rd_val = {31'h0000_0000, st_r.flags[i]};
            if (paddr == PUB_OFF[i])
                rd_val = {st_r.pub_en[i], 23'h00_0000, st_r.pub_idx[i]};
        end
        case (paddr)
            `ASE_OFF_SUB_START:
                rd_val = {st_r.sub_start_en, 23'h00_0000, st_r.sub_start_idx};
            `ASE_OFF_SUB_STOP:
                rd_val = {st_r.sub_stop_en, 23'h00_0000, st_r.sub_stop_idx};
            // All three enable views read the one store
            `ASE_OFF_IRQ_EN, `ASE_OFF_IRQ_SET, `ASE_OFF_IRQ_CLR:
                rd_val = ev_to_reg(st_r.irq_en);
            `ASE_OFF_RXEN:
                rd_val = {31'h0000_0000, st_r.rxen};
            `ASE_OFF_TXEN:
                rd_val = {31'h0000_0000, st_r.txen};
            `ASE_OFF_CLKGEN:
                rd_val = {31'h0000_0000, st_r.clkgen_en};
            `ASE_OFF_BUFCNT:
                rd_val = {{(32-`ASE_CNT_W){1'b0}}, st_r.bufcnt};
            default: ;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_nxt = st_r;
        ev     = 4'h0;

        // Two-stage synchronisers on the link pins
        st_nxt.sck_sync = {st_r.sck_sync[0], serial_bit_clock};
        st_nxt.fws_sync = {st_r.fws_sync[0], frame_word_select};
        st_nxt.sck_prev = st_r.sck_sync[1];
        if (sck_rise)
            st_nxt.fws_smp = st_r.fws_sync[1];

        st_nxt.rx_load = 1'b0;
        st_nxt.tx_load = 1'b0;

        // Run control; stop wins when both tasks land together
        unique case (st_r.run)
            ASE_IDLE: begin
                if (trig_start && !trig_stop) begin
                    st_nxt.run    = ASE_RUN;
                    st_nxt.rx_cnt = '0;
                    st_nxt.tx_cnt = '0;
                    ev[0]         = st_r.rxen;                // First pointer copy
                    ev[2]         = st_r.txen;
                end
            end
            ASE_RUN: begin
                if (word_edge && st_r.bufcnt != '0) begin
                    // Each word-select change closes one word
                    if (st_r.rxen) begin
                        if (st_r.rx_cnt == st_r.bufcnt - 1'b1) begin
                            st_nxt.rx_cnt = '0;
                            ev[0]         = 1'b1;
                        end else
                            st_nxt.rx_cnt = st_r.rx_cnt + 1'b1;
                    end
                    if (st_r.txen) begin
                        if (st_r.tx_cnt == st_r.bufcnt - 1'b1) begin
                            st_nxt.tx_cnt = '0;
                            ev[2]         = 1'b1;
                        end else
                            st_nxt.tx_cnt = st_r.tx_cnt + 1'b1;
                    end
                end
                if (word_edge && st_r.fws_sync[1])
                    ev[3] = 1'b1;                             // Rising is active
            end
        endcase
        if (trig_stop) begin
            st_nxt.run = ASE_IDLE;
            ev[1]      = 1'b1;                                // Stop always reports
        end

        st_nxt.rx_load = ev[0];
        st_nxt.tx_load = ev[2];

        // Publish each event on its channel when enabled
        st_nxt.pub_out = '0;
        for (int i = 0; i < `ASE_NUM_EV; i++) begin
            if (ev[i] && st_r.pub_en[i])
                st_nxt.pub_out[st_r.pub_idx[i]] = 1'b1;
        end

        // Register writes
        if (wr_acc) begin
            for (int i = 0; i < `ASE_NUM_EV; i++) begin
                if (paddr == EV_OFF[i])
                    st_nxt.flags[i] = pwdata[0];              // Zero clears
                if (paddr == PUB_OFF[i]) begin
                    st_nxt.pub_en[i]  = pwdata[`ASE_EN_BIT];
                    st_nxt.pub_idx[i] = pwdata[`ASE_IDX_W-1:0];
                end
            end
            case (paddr)
                `ASE_OFF_SUB_START: begin
                    st_nxt.sub_start_en  = pwdata[`ASE_EN_BIT];
                    st_nxt.sub_start_idx = pwdata[`ASE_IDX_W-1:0];
                end
                `ASE_OFF_SUB_STOP: begin
                    st_nxt.sub_stop_en  = pwdata[`ASE_EN_BIT];
                    st_nxt.sub_stop_idx = pwdata[`ASE_IDX_W-1:0];
                end
                // Set and clear views touch only the bits written as one
                `ASE_OFF_IRQ_EN:
                    st_nxt.irq_en = reg_to_ev(pwdata);
                `ASE_OFF_IRQ_SET:
                    st_nxt.irq_en = st_r.irq_en | reg_to_ev(pwdata);
                `ASE_OFF_IRQ_CLR:
                    st_nxt.irq_en = st_r.irq_en & ~reg_to_ev(pwdata);
                `ASE_OFF_RXEN:
                    st_nxt.rxen = pwdata[0];
                `ASE_OFF_TXEN:
                    st_nxt.txen = pwdata[0];
                `ASE_OFF_CLKGEN:
                    st_nxt.clkgen_en = pwdata[0];
                `ASE_OFF_BUFCNT:
                    st_nxt.bufcnt = pwdata[`ASE_CNT_W-1:0];
                default: ;
            endcase
        end

        // Hardware set wins over a software clear in the same cycle
        st_nxt.flags = st_nxt.flags | ev;

        // Read data captured in setup so it is stable in access
        if (rd_setup)
            st_nxt.prdata = rd_val;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // All controls to constants; publish and enables cleared, clock generator enable set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r               <= '0;
            st_r.run           <= ASE_IDLE;
            st_r.flags         <= '0;
            st_r.irq_en        <= `ASE_RST_IRQ_EN;
            st_r.pub_en        <= {`ASE_NUM_EV{1'(`ASE_RST_PUB >> `ASE_EN_BIT)}};
            st_r.pub_idx       <= '0;
            st_r.sub_start_en  <= 1'b0;
            st_r.sub_stop_en   <= 1'b0;
            st_r.rxen          <= 1'b0;
            st_r.txen          <= 1'b0;
            st_r.clkgen_en     <= `ASE_RST_CLKGEN;
            st_r.bufcnt        <= `ASE_RST_BUFCNT;
            st_r.sck_sync      <= 2'b00;   // Pins idle low, so no false edge after reset
            st_r.sck_prev      <= 1'b0;
            st_r.fws_sync      <= 2'b00;
            st_r.fws_smp       <= 1'b0;
            st_r.pub_out       <= '0;
            st_r.prdata        <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata                     = st_r.prdata;
    assign pready                     = 1'b1;
    assign pslverr                    = psel && penable && !addr_valid(paddr);
    assign transfer_running           = (st_r.run == ASE_RUN);
    assign master_clock_generator_run = (st_r.run == ASE_RUN) && st_r.clkgen_en;
    assign rx_pointer_load            = st_r.rx_load;
    assign tx_pointer_load            = st_r.tx_load;
    assign chan_publish               = st_r.pub_out[NUM_CHAN-1:0];
    // Level interrupt from any enabled flag
    assign irq                        = |(st_r.flags & st_r.irq_en);

endmodule : ase_event_ctrl

// ---- hw/ase_pkg.sv ----
// Types of the audio serial event control block
`include "ase_cfg.svh"
package ase_pkg;
    typedef enum logic {ASE_IDLE, ASE_RUN} ase_run_t;

    // Event order: 0 rx pointer, 1 stopped, 2 tx pointer, 3 frame begin
    typedef struct packed {
        ase_run_t                                   run;
        logic [`ASE_NUM_EV-1:0]                     flags;
        logic [`ASE_NUM_EV-1:0]                     irq_en;
        logic [`ASE_NUM_EV-1:0]                     pub_en;
        logic [`ASE_NUM_EV-1:0][`ASE_IDX_W-1:0]     pub_idx;
        logic                                       sub_start_en;
        logic [`ASE_IDX_W-1:0]                      sub_start_idx;
        logic                                       sub_stop_en;
        logic [`ASE_IDX_W-1:0]                      sub_stop_idx;
        logic                                       rxen;
        logic                                       txen;
        logic                                       clkgen_en;
        logic [`ASE_CNT_W-1:0]                      bufcnt;
        logic [`ASE_CNT_W-1:0]                      rx_cnt;
        logic [`ASE_CNT_W-1:0]                      tx_cnt;
        logic [1:0]                                 sck_sync;
        logic                                       sck_prev;
        logic [1:0]                                 fws_sync;
        logic                                       fws_smp;
        logic                                       rx_load;
        logic                                       tx_load;
        logic [255:0]                               pub_out;
        logic [31:0]                                prdata;
    } ase_state_t;
endpackage : ase_pkg

// ---- tb/ase_codec.sv ----
// Behavioural audio codec driving the link bit clock and word select
`timescale 1ns/10ps
module ase_codec (
    output logic serial_bit_clock,
    output logic frame_word_select
);
    initial begin
        serial_bit_clock = 1'b0;
        frame_word_select = 1'b0;
    end
    // Bit clock stands low between frames; 4 bits a word, 200 ns period
    task automatic send(input int n);
        repeat (n) begin
            #37 frame_word_select = ~frame_word_select;
            repeat (4) begin
                #100 serial_bit_clock = 1'b1;
                #100 serial_bit_clock = 1'b0;
            end
        end
    endtask : send
endmodule : ase_codec

// ---- tb/ase_event_ctrl_asserts.sv ----
// Port-level checker of the audio serial event control block
`timescale 1ns/10ps
module ase_chk #(
    parameter int NUM_CHAN = 256
) (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic                pslverr,
    input wire logic [NUM_CHAN-1:0] chan_trigger,
    input wire logic [NUM_CHAN-1:0] chan_publish,
    input wire logic                transfer_running,
    input wire logic                master_clock_generator_run,
    input wire logic                rx_pointer_load,
    input wire logic                tx_pointer_load,
    input wire logic                irq
);
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    // Write access phase, where a write takes effect
    assign wr = psel && penable && pwrite;
    ////////////////////////////////////////
    chk_start_runs: assert property (
        wr && paddr == 12'h000 && pwdata[0] && chan_trigger == '0 |=> transfer_running)
        else $error("start write did not start transfer");
    chk_stop_halts: assert property (
        wr && paddr == 12'h004 && pwdata[0] |=> !transfer_running && !master_clock_generator_run)
        else $error("stop write did not halt transfer");
    chk_clkgen_needs_run: assert property (
        master_clock_generator_run |-> transfer_running)
        else $error("clock generator runs while idle");
    chk_idle_holds: assert property (
        !transfer_running && !(wr && paddr == 12'h000) && chan_trigger == '0 |=> !transfer_running)
        else $error("transfer started without a task");
    chk_rx_load_run: assert property (
        rx_pointer_load |-> transfer_running || $past(transfer_running))
        else $error("rx pointer load while idle");
    chk_tx_load_run: assert property (
        tx_pointer_load |-> transfer_running || $past(transfer_running))
        else $error("tx pointer load while idle");
    chk_irq_clear_all: assert property (
        wr && paddr == 12'h308 && pwdata[7:0] == 8'hA6 |-> ##2 !irq)
        else $error("interrupt stayed up after all enables cleared");
    chk_enable_regs_ok: assert property (
        psel && penable && paddr inside {12'h300, 12'h304, 12'h308} |-> !pslverr)
        else $error("error response on an enable register");
    chk_pub_reset: assert property (
        $rose(presetn) |-> chan_publish == '0)
        else $error("publish active straight after reset");
    cover property (wr && paddr == 12'h000);
    cover property ($rose(irq));
    cover property (rx_pointer_load);
endmodule : ase_chk

bind ase_event_ctrl ase_chk #(.NUM_CHAN(NUM_CHAN)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .chan_trigger(chan_trigger),
    .chan_publish(chan_publish), .transfer_running(transfer_running),
    .master_clock_generator_run(master_clock_generator_run),
    .rx_pointer_load(rx_pointer_load), .tx_pointer_load(tx_pointer_load), .irq(irq));

// ---- tb/tb_audio_serial_event_control.sv ----
// Self-checking bench of the audio serial event control block
`timescale 1ns/10ps
module tb_audio_serial_event_control;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic         bclk, ws, run, gen_run, rx_ld, tx_ld, irq;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [255:0] trig, pub, last_pub;
    logic [11:0]  rst_regs [5] = '{12'h300, 12'h184, 12'h188, 12'h194, 12'h19C};
    int           n_errors, samples_checked, cyc, n_rx, n_tx, n_pub;
    int unsigned  ch, m, s, c, k;

    ase_event_ctrl #(.NUM_CHAN(256)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_bit_clock(bclk), .frame_word_select(ws), .chan_trigger(trig),
        .chan_publish(pub), .transfer_running(run), .master_clock_generator_run(gen_run),
        .rx_pointer_load(rx_ld), .tx_pointer_load(tx_ld), .irq(irq));
    ase_codec codec_u (.serial_bit_clock(bclk), .frame_word_select(ws));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Pulse counters and hang guard; reads see pre-edge values
    always @(posedge pclk) begin
        cyc++;
        n_rx += int'(rx_ld === 1'b1);
        n_tx += int'(tx_ld === 1'b1);
        if (pub !== '0) begin
            n_pub++;
            last_pub = pub;
        end
        if (cyc == 40000) begin
            n_errors++;
            $display("mismatch t=%0t timeout", $time);
            end_sim();
        end
    end
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // Pointer loads expected from words sent and buffer size
    function automatic int exp_loads(input int words, input int size);
        return (size == 0) ? 0 : words / size;
    endfunction : exp_loads
    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic pulse(input int unsigned n);
        @(posedge pclk);
        trig[n] <= 1'b1;
        @(posedge pclk);
        trig[n] <= 1'b0;
    endtask : pulse
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, trig} = '0;
        void'($urandom(53));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rst_regs[i]) begin
            apb(0, rst_regs[i], 0);
            chk(rd, 0, "reset value");
        end
        $display("test reset done");
        // Random enable patterns through plain, set and clear views
        repeat (8) begin
            m = $urandom & 32'hA6;
            s = $urandom & 32'hA6;
            c = $urandom & 32'hA6;
            apb(1, 12'h300, m);
            apb(0, 12'h300, 0);
            chk(rd, m, "enable reg");
            apb(1, 12'h304, s);
            apb(0, 12'h304, 0);
            chk(rd, m | s, "enable set");
            apb(1, 12'h308, c);
            apb(0, 12'h308, 0);
            chk(rd, (m | s) & ~c, "enable clear");
        end
        apb(0, 12'h200, 0);
        chk({rd[30:0], err}, 1, "unmapped read");
        $display("test enables done");
        // Stop while idle still raises and publishes the stopped event
        ch = $urandom_range(255);
        apb(1, 12'h308, 32'hA6);
        apb(1, 12'h304, 32'h4);
        apb(1, 12'h188, 32'h80000000 | ch);
        k = n_pub;
        apb(1, 12'h004, 1);
        repeat (2) @(posedge pclk);
        chk(n_pub - k, 1, "stop publish count");
        chk(last_pub[ch], 1, "publish channel");
        chk(irq, 1, "stopped irq");
        apb(0, 12'h108, 0);
        chk(rd, 1, "stopped flag");
        apb(1, 12'h108, 0);
        repeat (2) @(posedge pclk);
        chk(irq, 0, "irq after flag clear");
        apb(1, 12'h188, ch);
        apb(1, 12'h004, 1);
        repeat (2) @(posedge pclk);
        chk(n_pub - k, 1, "publish disabled");
        $display("test stop done");
        // Run with both directions and a three-word buffer
        k = $urandom_range(1);
        apb(1, 12'h510, k);
        apb(1, 12'h508, 1);
        apb(1, 12'h50C, 1);
        apb(1, 12'h550, 3);
        apb(1, 12'h000, 1);
        @(posedge pclk);
        chk(run, 1, "running");
        chk(gen_run, k, "clock generator");
        apb(0, 12'h104, 0);
        chk(rd, 1, "rx flag at start");
        n_rx = 0;
        n_tx = 0;
        codec_u.send(6);
        repeat (8) @(posedge pclk);
        chk(n_rx, exp_loads(6, 3), "rx pointer loads");
        chk(n_tx, exp_loads(6, 3), "tx pointer loads");
        apb(0, 12'h11C, 0);
        chk(rd, 1, "frame flag");
        apb(1, 12'h004, 1);
        @(posedge pclk);
        chk({run, gen_run}, 0, "halted");
        $display("test link done");
        // Tasks fired from subscribed channels
        ch = $urandom_range(255);
        apb(1, 12'h080, 32'h80000000 | ch);
        apb(1, 12'h084, 32'h80000000 | (255 - ch));
        pulse(ch);
        @(posedge pclk);
        chk(run, 1, "subscribed start");
        pulse(255 - ch);
        @(posedge pclk);
        chk(run, 0, "subscribed stop");
        $display("test subscribe done");
        end_sim();
    end
endmodule : tb_audio_serial_event_control
